//--- rtl/i2cm_axil.sv
// Purpose: AXI4-Lite slave in front of the register file
// Assumes: one write and one read outstanding at most
// Notes:   unmapped addresses answer SLVERR, reads of them return zero
`default_nettype none
`include "i2cm_params.svh"
module i2cm_axil
  import i2cm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire i2cm_addr_t s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  input  wire i2cm_word_t s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  input  wire i2cm_addr_t s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  output i2cm_word_t      s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  i2cm_reg_if.bus         rb
);
  logic       aw_held;
  logic       w_held;
  i2cm_addr_t aw_addr;
  i2cm_word_t w_data;
  logic [3:0] w_strb;

  // no new address or data while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign rb.wr_en   = aw_held && w_held;
  assign rb.wr_addr = aw_addr;
  assign rb.wr_data = w_data;
  assign rb.wr_strb = w_strb;
  assign rb.rd_en   = s_axi_arvalid && s_axi_arready;
  assign rb.rd_addr = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (sys_rst || rb.wr_en) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_held <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_held <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_addr <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `I2CM_RESP_OKAY;
    end else if (rb.wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= rb.wr_hit ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `I2CM_RESP_OKAY;
    end else if (rb.rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rb.rd_data;
      s_axi_rresp  <= rb.rd_hit ? `I2CM_RESP_OKAY : `I2CM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/i2cm_params.svh
// Purpose: offsets, field positions and reset values of the mode block
// Assumes: included by bare name from every design file that needs it
// Notes:   byte addresses on the register bus
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH

`define I2CM_OFF_MODE      8'h00
`define I2CM_OFF_WCOUNT    8'h04
`define I2CM_OFF_STATUS    8'h08

`define I2CM_MODE_RESET    16'h0000
`define I2CM_MODE_WMASK    16'hefff
`define I2CM_WCOUNT_RESET  16'h0000

`define I2CM_B_NACK        15
`define I2CM_B_FREE        14
`define I2CM_B_START       13
`define I2CM_B_STOP        11
`define I2CM_B_MASTER      10
`define I2CM_B_TRX         9
`define I2CM_B_RPT         7

`define I2CM_ST_CNT_LSB    0
`define I2CM_ST_HALTED     17
`define I2CM_ST_NACK       18
`define I2CM_ST_FSM_LSB    19

`define I2CM_RESP_OKAY     2'h0
`define I2CM_RESP_SLVERR   2'h2

`endif

//--- rtl/i2cm_pkg.sv
// Purpose: shared types of the mode control block
// Assumes: nothing
// Notes:   constants live in i2cm_params.svh
`default_nettype none
package i2cm_pkg;
  typedef logic [31:0] i2cm_word_t;
  typedef logic [7:0]  i2cm_addr_t;
  typedef enum logic [1:0] {
    I2CM_RUN       = 2'b00,
    I2CM_WAIT_SCL  = 2'b01,
    I2CM_WAIT_XFER = 2'b10,
    I2CM_HALT      = 2'b11
  } i2cm_halt_e;
endpackage
`default_nettype wire

//--- rtl/i2cm_reg_if.sv
// Purpose: register access strobes between bus slave and register file
// Assumes: one clock
// Notes:   wr_en and rd_en are one-cycle pulses
`default_nettype none
interface i2cm_reg_if;
  import i2cm_pkg::*;
  logic       wr_en;
  i2cm_addr_t wr_addr;
  i2cm_word_t wr_data;
  logic [3:0] wr_strb;
  logic       wr_hit;
  logic       rd_en;
  i2cm_addr_t rd_addr;
  i2cm_word_t rd_data;
  logic       rd_hit;
  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

//--- rtl/i2cm_top.sv
// Purpose: mode control register and its NACK, debug halt and START logic
// Assumes: the serial engine gives one-cycle event pulses on this clock
// Notes:   clk 10 MHz; sys_rst synchronous, active high
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
`include "i2cm_params.svh"
module i2cm_top
  import i2cm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire i2cm_addr_t   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire i2cm_word_t   s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire i2cm_addr_t   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output i2cm_word_t        s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         last_bit_rise,
  input  wire logic         ack_cycle,
  input  wire logic         word_done,
  input  wire logic         start_done,
  input  wire logic         stop_done,
  input  wire logic         scl_low,
  input  wire logic         slave_rx,
  input  wire logic         xfer_idle,
  input  wire logic         debug_halt,
  output logic [15:0]       mode_bits,
  output logic              ack_nack,
  output logic              start_gen,
  output logic              slave_enable,
  output logic              halt_req,
  output logic              scl_hold_low
);
  if (CNT_W != 16) begin : g_chk
    $error("i2cm_top: word_count_reg is 16 bits wide");
  end

  i2cm_reg_if rb ();

  logic [15:0]      mode;
  logic [15:0]      next_mode;
  logic [15:0]      wcount;
  logic [CNT_W:0]   count;
  logic             nack_from_req;
  logic             nack_clr;
  logic             receiving;
  logic             mode_wr;
  logic             brk;
  logic             enter_halt;
  i2cm_halt_e       hstate;
  i2cm_halt_e       next_hstate;
  logic             is_mst;

  i2cm_axil u_axil (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rb            (rb)
  );

  i2cm_wcnt #(.CNT_W(CNT_W)) u_wcnt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (start_done && is_mst),
    .dec      (word_done),
    .load_val (wcount),
    .count    (count)
  );

  assign is_mst    = mode[`I2CM_B_MASTER];
  assign mode_bits = mode;
  assign mode_wr   = rb.wr_en && rb.wr_addr == `I2CM_OFF_MODE;
  // slave direction comes from the received R/W bit in the engine
  assign receiving = is_mst ? !mode[`I2CM_B_TRX] : slave_rx;

  // address decode
  always_comb begin
    rb.wr_hit = 1'b0;
    if (rb.wr_addr == `I2CM_OFF_MODE) begin
      rb.wr_hit = 1'b1;
    end else if (rb.wr_addr == `I2CM_OFF_WCOUNT) begin
      rb.wr_hit = 1'b1;
    end
  end

  always_comb begin
    rb.rd_hit  = 1'b1;
    rb.rd_data = 32'h0;
    if (rb.rd_addr == `I2CM_OFF_MODE) begin
      rb.rd_data = {16'h0, mode & `I2CM_MODE_WMASK};
    end else if (rb.rd_addr == `I2CM_OFF_WCOUNT) begin
      rb.rd_data = {16'h0, wcount};
    end else if (rb.rd_addr == `I2CM_OFF_STATUS) begin
      rb.rd_data[`I2CM_ST_CNT_LSB +: CNT_W+1] = count;
      rb.rd_data[`I2CM_ST_HALTED]             = hstate == I2CM_HALT;
      rb.rd_data[`I2CM_ST_NACK]               = ack_nack;
      rb.rd_data[`I2CM_ST_FSM_LSB +: 2]       = hstate;
    end else begin
      rb.rd_hit = 1'b0;
    end
  end

  // hardware clears first, so a write landing in the same cycle wins
  always_comb begin
    next_mode = mode;
    if (nack_clr) next_mode[`I2CM_B_NACK] = 1'b0;
    if (start_done && is_mst) next_mode[`I2CM_B_START] = 1'b0;
    if (stop_done) begin
      next_mode[`I2CM_B_STOP]   = 1'b0;
      next_mode[`I2CM_B_MASTER] = 1'b0;
    end
    if (mode_wr) begin
      if (rb.wr_strb[0]) next_mode[7:0] = rb.wr_data[7:0];
      if (rb.wr_strb[1]) begin
        next_mode[15:8] = rb.wr_data[15:8] & 8'(`I2CM_MODE_WMASK >> 8);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= `I2CM_MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wcount <= `I2CM_WCOUNT_RESET;
    end else if (rb.wr_en && rb.wr_addr == `I2CM_OFF_WCOUNT) begin
      if (rb.wr_strb[0]) wcount[7:0] <= rb.wr_data[7:0];
      if (rb.wr_strb[1]) wcount[15:8] <= rb.wr_data[15:8];
    end
  end

  // ack decision frozen at the final data bit's rising edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_nack      <= 1'b0;
      nack_from_req <= 1'b0;
    end else if (last_bit_rise) begin
      ack_nack      <= mode[`I2CM_B_NACK] ||
                       (is_mst && !mode[`I2CM_B_RPT] &&
                        count == (CNT_W+1)'(1));
      nack_from_req <= mode[`I2CM_B_NACK];
    end else if (ack_cycle) begin
      nack_from_req <= 1'b0;
    end
  end

  assign nack_clr = ack_cycle && receiving && nack_from_req;

  // breakpoint handling
  assign brk = debug_halt && !mode[`I2CM_B_FREE];
  assign enter_halt = brk && (is_mst ? scl_low : xfer_idle);

  always_comb begin
    next_hstate = hstate;
    case (hstate)
      I2CM_RUN: begin
        if (enter_halt) begin
          next_hstate = I2CM_HALT;
        end else if (brk) begin
          next_hstate = is_mst ? I2CM_WAIT_SCL : I2CM_WAIT_XFER;
        end
      end
      I2CM_WAIT_SCL, I2CM_WAIT_XFER: begin
        if (!brk) begin
          next_hstate = I2CM_RUN;
        end else if (enter_halt) begin
          next_hstate = I2CM_HALT;
        end
      end
      I2CM_HALT: begin
        if (!brk) next_hstate = I2CM_RUN;
      end
      default: next_hstate = I2CM_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hstate <= I2CM_RUN;
    end else begin
      hstate <= next_hstate;
    end
  end

  // entry seen in the same cycle; a dropped or masked breakpoint frees at once
  assign halt_req     = brk && (hstate == I2CM_HALT || enter_halt);
  assign scl_hold_low = halt_req && is_mst;
  assign start_gen    = is_mst && mode[`I2CM_B_START] && !halt_req;
  // a slave only watches the bus while start_request is set
  assign slave_enable = !is_mst && mode[`I2CM_B_START]
                        && !halt_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_last_bit_req;
    last_bit_rise && mode[`I2CM_B_NACK];
  endsequence

  sequence s_ack_clear;
    ack_cycle && receiving && !mode_wr;
  endsequence

  a_rsvd_read_zero: assert property (
    rb.rd_addr == `I2CM_OFF_MODE |->
      rb.rd_data[31:16] == 16'h0 && !rb.rd_data[12])
    else $error("reserved mode bits read non-zero");

  a_reset_zero: assert property (disable iff (1'b0)
    sys_rst |=> mode == 16'h0 && count == '0)
    else $error("mode register not zero after reset");

  a_slave_ack: assert property (
    last_bit_rise && !is_mst && !mode[`I2CM_B_NACK] |=> !ack_nack)
    else $error("slave receiver failed to acknowledge");

  a_master_last_nack: assert property (
    last_bit_rise && is_mst && !mode[`I2CM_B_RPT] &&
    count == (CNT_W+1)'(1) |=> ack_nack)
    else $error("master receiver did not NACK last word");

  a_nack_one_shot: assert property (
    s_last_bit_req ##[1:8] s_ack_clear
      |-> ack_nack ##1 !mode[`I2CM_B_NACK])
    else $error("requested NACK not sent or not cleared");

  a_halt_scl_low: assert property (
    brk && is_mst && scl_low |-> halt_req && scl_hold_low
      ##1 (hstate == I2CM_HALT || !brk))
    else $error("master did not halt with SCL low");

  a_halt_wait_scl: assert property (
    hstate == I2CM_RUN && brk && is_mst && !scl_low |->
      !halt_req ##1 (hstate == I2CM_WAIT_SCL || !brk || mode_wr ||
                     stop_done))
    else $error("master halted while SCL high");

  a_slave_halt_done: assert property (
    !is_mst && hstate != I2CM_HALT && !xfer_idle |-> !halt_req)
    else $error("slave halted mid transfer");

  a_free_run: assert property (
    mode[`I2CM_B_FREE] |-> !halt_req ##1 (hstate == I2CM_RUN || mode_wr))
    else $error("free-run ignored breakpoint rule");

  a_start_issue: assert property (
    $rose(mode[`I2CM_B_START]) && is_mst && !halt_req |-> start_gen)
    else $error("START not requested in master mode");

  a_start_clear: assert property (
    start_done && is_mst && !mode_wr |=> !mode[`I2CM_B_START])
    else $error("start_request not cleared after START");

  a_slave_monitor: assert property (
    !is_mst |-> slave_enable == (mode[`I2CM_B_START] && !halt_req))
    else $error("slave bus watch does not follow start_request");

  a_count_load: assert property (
    start_done && is_mst |=>
      count == (($past(wcount) == 16'h0) ? (CNT_W+1)'(65536)
                                         : {1'b0, $past(wcount)}))
    else $error("word counter load wrong");

  a_count_dec: assert property (
    word_done && !start_done && count != '0 |=>
      count == $past(count) - 1'b1 && $stable(wcount))
    else $error("word counter did not count down by one");
endmodule
`default_nettype wire

//--- rtl/i2cm_wcnt.sv
// Purpose: internal word counter of the transfer
// Assumes: load and dec never both matter; load wins
// Notes:   a programmed zero stands for 2**CNT_W words
`default_nettype none
module i2cm_wcnt #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic             dec,
  input  wire logic [CNT_W-1:0] load_val,
  output logic      [CNT_W:0]   count
);
  if (CNT_W < 1 || CNT_W > 16) begin : g_chk
    $error("i2cm_wcnt: CNT_W must be 1 to 16");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else if (load) begin
      count <= (load_val == '0) ? {1'b1, {CNT_W{1'b0}}}
                                : {1'b0, load_val};
    end else if (dec && count != '0) begin
      count <= count - 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- sim/i2c_mode_control_upper_tb.sv
// Purpose: self-checking bench of the mode control block
// Assumes: engine model drives the serial event inputs
// Notes:   expectations come from the bench's own count and mode images
`default_nettype none
`include "i2cm_params.svh"
module i2c_mode_control_upper_tb import i2cm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic       s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic       s_axi_arready, s_axi_rvalid, s_axi_rready;
  i2cm_addr_t s_axi_awaddr, s_axi_araddr;
  i2cm_word_t s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic       last_bit_rise, ack_cycle, word_done, start_done, stop_done;
  logic       scl_low, slave_rx, xfer_idle, debug_halt, ack_nack;
  logic       start_gen, slave_enable, halt_req, scl_hold_low;
  logic       byte_go, stop_go, byte_end;
  logic [15:0] mode_bits;
  logic [15:0] wcs [3];
  int         fail_count, n_compared, m_cnt;

  i2cm_top #(.CNT_W(16)) dut (.clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .last_bit_rise, .ack_cycle, .word_done, .start_done, .stop_done,
    .scl_low, .slave_rx, .xfer_idle, .debug_halt, .mode_bits, .ack_nack,
    .start_gen, .slave_enable, .halt_req, .scl_hold_low);
  i2cm_engine_model eng (.clk, .sys_rst, .start_gen, .halt_req, .byte_go,
    .stop_go, .byte_end, .last_bit_rise, .ack_cycle, .word_done,
    .start_done, .stop_done, .xfer_idle);

  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input i2cm_addr_t a, input i2cm_word_t v,
                    input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input i2cm_addr_t a, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // dh raises the breakpoint once the byte is under way
  task automatic xfer(input logic dh);
    int k;
    k = 0;
    byte_go <= 1'b1;
    @(posedge clk);
    byte_go    <= 1'b0;
    debug_halt <= dh;
    do begin
      @(posedge clk);
      k++;
      if (k == 1) chk("halt_mid", halt_req, 1'b0);
    end while (!byte_end);
    chk("halt_end", halt_req, dh);
  endtask

  task automatic go_start(input i2cm_word_t m);
    wr(`I2CM_OFF_MODE, m, `I2CM_RESP_OKAY);
    while (!start_done) begin
      @(posedge clk);
    end
    chk("start_gen", start_gen, 1'b1);
    @(posedge clk);
    chk("start_clr", mode_bits, m[15:0] & 16'hdfff);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, byte_go, stop_go, scl_low, slave_rx, debug_halt} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    fail_count = 0;
    n_compared = 0;
    sys_rst    = 1'b1;
    void'($urandom(56));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`I2CM_OFF_MODE, `I2CM_RESP_OKAY);
    chk("mode_rst", d, 32'h0);
    rd(`I2CM_OFF_WCOUNT, `I2CM_RESP_OKAY);
    chk("wcount_rst", d, 32'h0);
    rd(8'h0c, `I2CM_RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    wr(`I2CM_OFF_STATUS, 32'h1, `I2CM_RESP_SLVERR);
    // start, stop and master kept clear so nothing fires on its own
    for (int i = 0; i < 6; i++) begin
      d = $urandom & 32'hffff_d3ff;
      wr(`I2CM_OFF_MODE, d, `I2CM_RESP_OKAY);
      m_cnt = int'(d[15:0] & 16'hefff);
      chk("mode_out", mode_bits, m_cnt);
      chk("slave_en", slave_enable, 1'b0);
      rd(`I2CM_OFF_MODE, `I2CM_RESP_OKAY);
      chk("mode_rd", d, m_cnt);
    end
    wcs[0] = 16'h0003;
    wcs[1] = 16'h0000;
    wcs[2] = 16'($urandom_range(65535, 4));
    foreach (wcs[i]) begin
      wr(`I2CM_OFF_WCOUNT, {16'h0, wcs[i]}, `I2CM_RESP_OKAY);
      m_cnt = (wcs[i] == 16'h0) ? 65536 : int'(wcs[i]);
      go_start(32'h0000_2400);
      for (int j = 0; j < 3; j++) begin
        rd(`I2CM_OFF_STATUS, `I2CM_RESP_OKAY);
        chk("counter", {15'h0, d[16:0]}, m_cnt);
        xfer(1'b0);
        chk("ack_nack", ack_nack, m_cnt == 1);
        m_cnt = m_cnt - 1;
      end
      rd(`I2CM_OFF_WCOUNT, `I2CM_RESP_OKAY);
      chk("wcount", d, {16'h0, wcs[i]});
      wr(`I2CM_OFF_MODE, 32'h0000_0c00, `I2CM_RESP_OKAY);
      stop_go <= 1'b1;
      @(posedge clk);
      stop_go <= 1'b0;
      repeat (2) @(posedge clk);
      chk("stop_clr", mode_bits, 16'h0000);
    end
    slave_rx <= 1'b1;
    wr(`I2CM_OFF_MODE, 32'h0000_2000, `I2CM_RESP_OKAY);
    chk("slave_en", slave_enable, 1'b1);
    chk("start_gen", start_gen, 1'b0);
    xfer(1'b0);
    chk("ack_nack", ack_nack, 1'b0);
    // request placed well before the last data bit of the next byte
    wr(`I2CM_OFF_MODE, 32'h0000_a000, `I2CM_RESP_OKAY);
    xfer(1'b0);
    chk("ack_nack", ack_nack, 1'b1);
    chk("nack_clr", mode_bits, 16'h2000);
    xfer(1'b1);
    chk("ack_nack", ack_nack, 1'b0);
    debug_halt <= 1'b0;
    slave_rx   <= 1'b0;
    wr(`I2CM_OFF_MODE, 32'h0, `I2CM_RESP_OKAY);
    chk("slave_en", slave_enable, 1'b0);
    // master entered from run with SCL high, then again with SCL low
    scl_low    <= 1'b0;
    wr(`I2CM_OFF_MODE, 32'h0000_0400, `I2CM_RESP_OKAY);
    debug_halt <= 1'b1;
    @(posedge clk);
    chk("halt_high", halt_req, 1'b0);
    scl_low <= 1'b1;
    @(posedge clk);
    chk("halt_fall", halt_req, 1'b1);
    debug_halt <= 1'b0;
    @(posedge clk);
    debug_halt <= 1'b1;
    @(posedge clk);
    chk("halt_low", halt_req, 1'b1);
    chk("scl_hold", scl_hold_low, 1'b1);
    go_start(32'h0000_6400);
    chk("halt_free", halt_req, 1'b0);
    debug_halt <= 1'b0;
    wr(`I2CM_OFF_MODE, 32'h0, `I2CM_RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire

//--- sim/i2cm_engine_model.sv
// Purpose: serial engine stand-in that makes byte and START/STOP events
// Assumes: one clock, pulses one cycle wide, halt_req freezes the byte
// Notes:   GAP stretches a byte, START_DLY delays the START report
`default_nettype none
module i2cm_engine_model #(
  parameter int GAP       = 1,
  parameter int START_DLY = 6
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start_gen,
  input  wire logic halt_req,
  input  wire logic byte_go,
  input  wire logic stop_go,
  output logic      byte_end,
  output logic      last_bit_rise,
  output logic      ack_cycle,
  output logic      word_done,
  output logic      start_done,
  output logic      stop_done,
  output logic      xfer_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  int   step;
  int   wait_cnt;
  logic armed;

  // last data bit always comes before the ack cycle of the same byte
  always_ff @(posedge clk) begin
    last_bit_rise <= 1'b0;
    ack_cycle     <= 1'b0;
    word_done     <= 1'b0;
    byte_end      <= 1'b0;
    if (sys_rst) begin
      step      <= 0;
      xfer_idle <= 1'b1;
    end else if (byte_go) begin
      step      <= 1;
      xfer_idle <= 1'b0;
    end else if (step != 0 && !halt_req) begin
      step <= step + 1;
      if (step == 3 * GAP) last_bit_rise <= 1'b1;
      if (step == 6 * GAP) ack_cycle <= 1'b1;
      if (step == 7 * GAP) word_done <= 1'b1;
      if (step == 8 * GAP) begin
        step      <= 0;
        xfer_idle <= 1'b1;
        byte_end  <= 1'b1;
      end
    end
  end

  // one START report per request; re-armed once the request drops
  always_ff @(posedge clk) begin
    start_done <= 1'b0;
    stop_done  <= stop_go & ~sys_rst;
    if (sys_rst || !start_gen) begin
      wait_cnt <= 0;
      armed    <= 1'b1;
    end else if (armed) begin
      if (wait_cnt == START_DLY) begin
        start_done <= 1'b1;
        armed      <= 1'b0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire
